//--- rtl/alz_params.svh
// Constants of the ambient-light zone control block: offsets, fields, resets, timing.
// Assumes a 50 MHz sys_clk_in and byte-wide register access from the serial interface logic.
// Functional notes
// - Light control runs only when configuration bits 4 and 3 are both one.
// - Bit 3 enables sensing; bit 4 lets the zone steer LED current. Here sensing also needs bit 4 and device enable.
// - Four boundaries give five zones; each zone picks its own target register.
// - Boundaries reset in order to 0x33, 0x66, 0x99, 0xCC.
// - Each boundary register is eight bits, host readable and writable.
// - Zone targets reset to 0x19, 0x33, 0x4C, 0x66, 0x7F.
// - Configuration bits 6:5 pick the sensor input; 01 selects the first.
// - Configuration bits 2:0 set averaging period; 100 is 512 ms, 011 256 ms.
// - Boundary codes are steps of a 1 V span over 255 plus 4 mV.
// - Selected target code maps to current via exponential or linear mapping.
// - With PWM enabled, current is full scale times target times duty cycle.
// - The averager starts at zone 0 after enable.
// - Zone rises after two consecutive upward averaged moves; applies next period.
// - Zone falls likewise after two consecutive downward averaged moves.
// - On zone change current ramps stepwise; ramp setting 0x2D gives 16.384 ms per step.
// - A new zone mid-ramp retargets from the present level.
// - Resistor select 0x04 gives first input 2.27 kohm, second input high impedance.
// - General config: bit 7 simple enable, 6 PWM polarity, 5 PWM enable, 0 device enable; bit 7 is stored but has no effect here.
// - General config bits 4:2 select full scale current; 101 is 22.5 mA.
// - General config bit 1 selects mapping; 0 is exponential.
// - Open-drain active-low interrupt pulls low on each zone change.
// - Reading the information register releases the interrupt.
`ifndef ALZ_PARAMS_SVH
`define ALZ_PARAMS_SVH

`define ALZ_CLK_HZ 50000000
`define ALZ_SAMPLE_BASE_US 1000
`define ALZ_RAMP_BASE_US 512
`define ALZ_SAMPLE_SHIFT 5

`define ALZ_ADDR_GEN 8'h00
`define ALZ_ADDR_ALS 8'h01
`define ALZ_ADDR_RES 8'h02
`define ALZ_ADDR_RAMP 8'h03
`define ALZ_ADDR_INFO 8'h04
`define ALZ_ADDR_ZB0 8'h05
`define ALZ_ADDR_ZT0 8'h09
`define ALZ_ADDR_AVG 8'h0E

`define ALZ_GEN_RESET 8'h00
`define ALZ_ALS_RESET 8'h00
`define ALZ_RES_RESET 8'h00
`define ALZ_RAMP_RESET 8'h00
`define ALZ_ZB_RESET {8'hCC, 8'h99, 8'h66, 8'h33}
`define ALZ_ZT_RESET {8'h7F, 8'h66, 8'h4C, 8'h33, 8'h19}

`define ALZ_GEN_SIMPLE 7
`define ALZ_GEN_PWM_POL 6
`define ALZ_GEN_PWM_EN 5
`define ALZ_GEN_FS_HI 4
`define ALZ_GEN_FS_LO 2
`define ALZ_GEN_MAP 1
`define ALZ_GEN_DEV_EN 0
`define ALZ_ALS_SEL_HI 6
`define ALZ_ALS_SEL_LO 5
`define ALZ_ALS_CTRL 4
`define ALZ_ALS_SENSE 3
`define ALZ_ALS_AVG_HI 2
`define ALZ_ALS_AVG_LO 0
`define ALZ_RAMP_UP_HI 5
`define ALZ_RAMP_UP_LO 3
`define ALZ_RAMP_DN_HI 2
`define ALZ_RAMP_DN_LO 0
`define ALZ_RES_A_HI 3
`define ALZ_RES_A_LO 0
`define ALZ_RES_B_HI 7
`define ALZ_RES_B_LO 4
`define ALZ_NUM_BOUNDS 4

`define ALZ_SEL_A 2'h1
`define ALZ_SEL_B 2'h2
`define ALZ_SEL_MAX 2'h3
`define ALZ_DIR_NONE 2'h0
`define ALZ_DIR_UP 2'h1
`define ALZ_DIR_DOWN 2'h2
`define ALZ_ZONE_TOP 3'h4
`define ALZ_LAST_SAMPLE 5'h1F

`endif

//--- rtl/alz_pkg.sv
// Types of the ambient-light zone control block.
// Assumes alz_params.svh is on the include path.
package alz_pkg;

  typedef enum logic [1:0] {
    ALZ_IDLE = 2'b01,
    ALZ_RUN = 2'b10
  } alz_mode_t;

  typedef struct packed {
    alz_mode_t mode;
    logic [7:0] gen;
    logic [7:0] als;
    logic [7:0] res;
    logic [7:0] ramp;
    logic [3:0][7:0] zb;
    logic [4:0][7:0] zt;
    logic [31:0] samp_cnt;
    logic [4:0] samp_idx;
    logic [12:0] acc;
    logic [7:0] avg;
    logic [2:0] est;
    logic [2:0] zone;
    logic [1:0] last_dir;
    logic [31:0] ramp_cnt;
    logic [7:0] level;
    logic int_flag;
    logic drive;
    logic [7:0] rdata;
  } alz_state_t;

endpackage

//--- rtl/alz_zone_ctrl.sv
// Ambient-light zone control: averaging, zone tracking, current ramp, interrupt and registers.
// Assumes register accesses arrive already decoded from the serial interface as byte strobes,
// and the two sensor inputs arrive as 8-bit codes synchronous to sys_clk_in.
`timescale 1ns/100ps
`include "alz_params.svh"

module alz_zone_ctrl
  import alz_pkg::*;
#(
  parameter int unsigned SAMPLE_BASE_CYCLES = (`ALZ_CLK_HZ / 1000000) * `ALZ_SAMPLE_BASE_US,
  parameter int unsigned RAMP_BASE_CYCLES = (`ALZ_CLK_HZ / 1000000) * `ALZ_RAMP_BASE_US
) (
  input wire logic sys_clk_in,            // System clock, 50 MHz
  input wire logic reset_n_in,            // Asynchronous reset, active low
  input wire logic [7:0] reg_addr_in,     // Register address
  input wire logic reg_wr_in,             // Write strobe, one cycle
  input wire logic reg_rd_in,             // Read strobe, one cycle
  input wire logic [7:0] reg_wdata_in,    // Write data
  output logic [7:0] reg_rdata_out,       // Read data, valid cycle after strobe
  input wire logic [7:0] light_sensor_in_a, // First sensor input code
  input wire logic [7:0] light_sensor_in_b, // Second sensor input code
  input wire logic pwm_in,                // PWM input level
  output logic [7:0] led_level_out,       // Ramped brightness code
  output logic led_map_linear_out,        // Mapping select, 1 linear
  output logic [2:0] full_scale_led_current_out, // Full scale current select
  output logic led_drive_out,             // Current sink on
  output logic [3:0] sensor_a_res_out,    // Resistor code, first input
  output logic [3:0] sensor_b_res_out,    // Resistor code, second input
  output logic int_out,                   // Interrupt pin output value
  output logic int_oe_n_out               // Interrupt pin enable, low drives
);

  alz_state_t st_reg;
  alz_state_t st_next;

  logic [3:0] above;
  logic [7:0] sample;
  logic [12:0] acc_sum;
  logic [7:0] avg_now;
  logic [2:0] raw_zone;
  logic [31:0] samp_limit;
  logic [31:0] ramp_limit;
  logic [7:0] target;
  logic [2:0] ramp_code;
  logic als_on;

  ////////////////////////////////////////////////////////////////////////////////
  // Sensor select and averaging arithmetic

  always_comb begin
    case (st_reg.als[`ALZ_ALS_SEL_HI:`ALZ_ALS_SEL_LO])
      `ALZ_SEL_A: sample = light_sensor_in_a;
      `ALZ_SEL_B: sample = light_sensor_in_b;
      `ALZ_SEL_MAX: sample = (light_sensor_in_a > light_sensor_in_b) ? light_sensor_in_a : light_sensor_in_b;
      default: sample = 8'h00;
    endcase
  end

  // Codes compare directly; the analog front end applies the 1 V span and offset
  assign acc_sum = st_reg.acc + {5'h00, sample};
  assign avg_now = acc_sum[12:`ALZ_SAMPLE_SHIFT];

  genvar gi;
  generate
    for (gi = 0; gi < `ALZ_NUM_BOUNDS; gi++) begin : g_bound
      assign above[gi] = (avg_now >= st_reg.zb[gi]);
    end
  endgenerate

  // Boundaries assumed ascending; unordered ones still give a zone in range
  assign raw_zone = {2'h0, above[0]} + {2'h0, above[1]} + {2'h0, above[2]} + {2'h0, above[3]};

  // Averaging period is 32 samples at 1 ms << code
  assign samp_limit = SAMPLE_BASE_CYCLES << st_reg.als[`ALZ_ALS_AVG_HI:`ALZ_ALS_AVG_LO];

  assign target = st_reg.zt[st_reg.zone];
  assign ramp_code = (target > st_reg.level) ? st_reg.ramp[`ALZ_RAMP_UP_HI:`ALZ_RAMP_UP_LO]
                                             : st_reg.ramp[`ALZ_RAMP_DN_HI:`ALZ_RAMP_DN_LO];
  assign ramp_limit = RAMP_BASE_CYCLES << ramp_code;

  assign als_on = st_reg.als[`ALZ_ALS_CTRL] & st_reg.als[`ALZ_ALS_SENSE] & st_reg.gen[`ALZ_GEN_DEV_EN];

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic period_end;
    logic zone_change;
    logic [1:0] dir;
    logic [7:0] idx;
    period_end = 1'b0;
    zone_change = 1'b0;
    dir = `ALZ_DIR_NONE;
    idx = 8'h00;
    st_next = st_reg;

    // Register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        `ALZ_ADDR_GEN: st_next.gen = reg_wdata_in;
        `ALZ_ADDR_ALS: st_next.als = reg_wdata_in;
        `ALZ_ADDR_RES: st_next.res = reg_wdata_in;
        `ALZ_ADDR_RAMP: st_next.ramp = reg_wdata_in;
        default: begin
          if (reg_addr_in >= `ALZ_ADDR_ZB0 && reg_addr_in < `ALZ_ADDR_ZT0) begin
            idx = reg_addr_in - `ALZ_ADDR_ZB0;
            st_next.zb[idx[1:0]] = reg_wdata_in;
          end else if (reg_addr_in >= `ALZ_ADDR_ZT0 && reg_addr_in < `ALZ_ADDR_AVG) begin
            idx = reg_addr_in - `ALZ_ADDR_ZT0;
            st_next.zt[idx[2:0]] = reg_wdata_in;
          end
        end
      endcase
    end

    // Register reads; unmapped addresses read zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        `ALZ_ADDR_GEN: st_next.rdata = st_reg.gen;
        `ALZ_ADDR_ALS: st_next.rdata = st_reg.als;
        `ALZ_ADDR_RES: st_next.rdata = st_reg.res;
        `ALZ_ADDR_RAMP: st_next.rdata = st_reg.ramp;
        `ALZ_ADDR_INFO: st_next.rdata = {st_reg.int_flag, 1'b0, st_reg.est, st_reg.zone};
        `ALZ_ADDR_AVG: st_next.rdata = st_reg.avg;
        default: begin
          st_next.rdata = 8'h00;
          if (reg_addr_in >= `ALZ_ADDR_ZB0 && reg_addr_in < `ALZ_ADDR_ZT0) begin
            idx = reg_addr_in - `ALZ_ADDR_ZB0;
            st_next.rdata = st_reg.zb[idx[1:0]];
          end else if (reg_addr_in >= `ALZ_ADDR_ZT0 && reg_addr_in < `ALZ_ADDR_AVG) begin
            idx = reg_addr_in - `ALZ_ADDR_ZT0;
            st_next.rdata = st_reg.zt[idx[2:0]];
          end
        end
      endcase
      if (reg_addr_in == `ALZ_ADDR_INFO) begin
        st_next.int_flag = 1'b0;
      end
    end

    case (st_reg.mode)
      ALZ_IDLE: begin
        // Averager and ramp restart from zone 0 and zero current
        st_next.samp_cnt = 32'h0;
        st_next.samp_idx = 5'h00;
        st_next.acc = 13'h0000;
        st_next.est = 3'h0;
        st_next.zone = 3'h0;
        st_next.last_dir = `ALZ_DIR_NONE;
        st_next.ramp_cnt = 32'h0;
        st_next.level = 8'h00;
        if (als_on) begin
          st_next.mode = ALZ_RUN;
        end
      end
      ALZ_RUN: begin
        if (!als_on) begin
          st_next.mode = ALZ_IDLE;
        end else begin
          // Sampling and averaging
          if (st_reg.samp_cnt >= samp_limit - 32'h1) begin
            st_next.samp_cnt = 32'h0;
            st_next.samp_idx = st_reg.samp_idx + 5'h01;
            st_next.acc = acc_sum;
            if (st_reg.samp_idx == `ALZ_LAST_SAMPLE) begin
              period_end = 1'b1;
              st_next.acc = 13'h0000;
              st_next.avg = avg_now;
            end
          end else begin
            st_next.samp_cnt = st_reg.samp_cnt + 32'h1;
          end

          if (period_end) begin
            if (raw_zone > st_reg.est) begin
              dir = `ALZ_DIR_UP;
              st_next.est = st_reg.est + 3'h1;
            end else if (raw_zone < st_reg.est) begin
              dir = `ALZ_DIR_DOWN;
              st_next.est = st_reg.est - 3'h1;
            end
            st_next.last_dir = dir;
            // Two moves in one direction commit; takes effect from the next period
            if (dir != `ALZ_DIR_NONE && dir == st_reg.last_dir && st_next.est != st_reg.zone) begin
              st_next.zone = st_next.est;
              zone_change = 1'b1;
            end
          end

          // Ramp toward the current target; a retarget keeps the present level
          if (st_reg.level == target) begin
            st_next.ramp_cnt = 32'h0;
          end else if (st_reg.ramp_cnt >= ramp_limit - 32'h1) begin
            st_next.ramp_cnt = 32'h0;
            st_next.level = (target > st_reg.level) ? st_reg.level + 8'h01 : st_reg.level - 8'h01;
          end else begin
            st_next.ramp_cnt = st_reg.ramp_cnt + 32'h1;
          end
        end
      end
      default: st_next.mode = ALZ_IDLE;
    endcase

    // Set wins over a clearing read in the same cycle
    if (zone_change) begin
      st_next.int_flag = 1'b1;
    end

    // PWM gating averages the current by the duty cycle
    st_next.drive = als_on && (st_reg.level != 8'h00) &&
                    (!st_reg.gen[`ALZ_GEN_PWM_EN] || (pwm_in ^ st_reg.gen[`ALZ_GEN_PWM_POL]));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg.mode <= ALZ_IDLE;
      st_reg.gen <= `ALZ_GEN_RESET;
      st_reg.als <= `ALZ_ALS_RESET;
      st_reg.res <= `ALZ_RES_RESET;
      st_reg.ramp <= `ALZ_RAMP_RESET;
      st_reg.zb <= `ALZ_ZB_RESET;
      st_reg.zt <= `ALZ_ZT_RESET;
      st_reg.samp_cnt <= 32'h0;
      st_reg.samp_idx <= 5'h00;
      st_reg.acc <= 13'h0000;
      st_reg.avg <= 8'h00;
      st_reg.est <= 3'h0;
      st_reg.zone <= 3'h0;
      st_reg.last_dir <= `ALZ_DIR_NONE;
      st_reg.ramp_cnt <= 32'h0;
      st_reg.level <= 8'h00;
      st_reg.int_flag <= 1'b0;
      st_reg.drive <= 1'b0;
      st_reg.rdata <= 8'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state flops, except int_out, which is tied low, and int_oe_n_out, the inverted int_flag

  assign reg_rdata_out = st_reg.rdata;
  assign led_level_out = st_reg.level;
  assign led_map_linear_out = st_reg.gen[`ALZ_GEN_MAP];
  assign full_scale_led_current_out = st_reg.gen[`ALZ_GEN_FS_HI:`ALZ_GEN_FS_LO];
  assign led_drive_out = st_reg.drive;
  assign sensor_a_res_out = st_reg.res[`ALZ_RES_A_HI:`ALZ_RES_A_LO];
  assign sensor_b_res_out = st_reg.res[`ALZ_RES_B_HI:`ALZ_RES_B_LO];
  assign int_out = 1'b0;
  assign int_oe_n_out = ~st_reg.int_flag;

endmodule // alz_zone_ctrl

//--- verification/alz_zone_ctrl_assertions.sv
// Port checker for the zone control block: bus answers, ramp pacing, interrupt pin.
// Assumes binding to alz_zone_ctrl and a ramp base of at least two cycles.
`timescale 1ns/100ps
module alz_zone_ctrl_checker #(
  parameter int unsigned RAMP_BASE_CYCLES = 3
) (
  input wire logic sys_clk_in, // Clock
  input wire logic reset_n_in, // Reset, active low
  input wire logic [7:0] reg_addr_in, // Address
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  input wire logic [7:0] reg_wdata_in, // Write data
  input wire logic [7:0] reg_rdata_out, // Read data
  input wire logic [7:0] led_level_out, // Ramped level
  input wire logic led_map_linear_out, // Mapping select
  input wire logic [2:0] full_scale_led_current_out, // Full scale select
  input wire logic led_drive_out, // Sink on
  input wire logic [3:0] sensor_a_res_out, // Resistor code A
  input wire logic [3:0] sensor_b_res_out, // Resistor code B
  input wire logic int_out, // Pin value
  input wire logic int_oe_n_out // Pin enable, low drives
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic info_rd;
  assign info_rd = reg_rd_in && reg_addr_in == 8'h04;
  a_int_low_only: assert property (
    int_out == 1'b0) else $error("interrupt pin value not low");
  a_int_holds_unread: assert property (
    !int_oe_n_out && !info_rd |=> !int_oe_n_out) else $error("interrupt dropped without read");
  a_int_read_release: assert property (
    !int_oe_n_out && info_rd |=> int_oe_n_out) else $error("interrupt kept after info read");
  a_res_follows_write: assert property (
    (reg_wr_in && reg_addr_in == 8'h02) ##1 !reg_wr_in |=>
    {sensor_b_res_out, sensor_a_res_out} == $past(reg_wdata_in, 2)) else $error("resistor codes wrong");
  a_gen_follows_write: assert property (
    (reg_wr_in && reg_addr_in == 8'h00) ##1 !reg_wr_in |=>
    {4'h0, full_scale_led_current_out, led_map_linear_out} == ($past(reg_wdata_in, 2) & 8'h1E) >> 1)
    else $error("general fields wrong");
  a_unmapped_zero: assert property (
    (reg_rd_in && reg_addr_in > 8'h0E) ##1 !reg_rd_in |=> reg_rdata_out == 8'h00) else $error("unmapped read");
  a_rdata_stands: assert property (
    !reg_rd_in ##1 !reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
  a_level_one_step: assert property (
    $changed(led_level_out) && led_level_out != 8'h00 |->
    led_level_out == $past(led_level_out) + 8'h01 || led_level_out == $past(led_level_out) - 8'h01)
    else $error("level jumped");
  a_level_paced: assert property (
    $changed(led_level_out) && led_level_out != 8'h00 && RAMP_BASE_CYCLES > 1 |=>
    $stable(led_level_out) || led_level_out == 8'h00) else $error("level stepped too fast");
  a_drive_needs_level: assert property (
    led_drive_out |-> led_level_out != 8'h00 || $past(led_level_out) != 8'h00) else $error("drive at zero");
endmodule // alz_zone_ctrl_checker

bind alz_zone_ctrl alz_zone_ctrl_checker #(.RAMP_BASE_CYCLES(RAMP_BASE_CYCLES)) u_chk (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .led_level_out(led_level_out), .led_map_linear_out(led_map_linear_out),
  .full_scale_led_current_out(full_scale_led_current_out), .led_drive_out(led_drive_out),
  .sensor_a_res_out(sensor_a_res_out), .sensor_b_res_out(sensor_b_res_out),
  .int_out(int_out), .int_oe_n_out(int_oe_n_out));

//--- verification/alz_light_model.sv
// Sensor front end: turns requested light codes into the codes on both inputs.
// Assumes codes of a 1 V span in 255 steps plus offset, clocked by sys_clk_in.
`timescale 1ns/100ps
module alz_light_model #(
  parameter int unsigned SLEW = 0
) (
  input wire logic clk_in, // Clock
  input wire logic reset_n_in, // Reset, active low
  input wire logic [7:0] goal_a_in, // Requested code A
  input wire logic [7:0] goal_b_in, // Requested code B
  output logic [7:0] sensor_a_out, // Code on input A
  output logic [7:0] sensor_b_out // Code on input B
);
  // Slow mode walks one code a cycle, like a filtered photodiode
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sensor_a_out <= 8'h00;
      sensor_b_out <= 8'h00;
    end else if (SLEW == 0) begin
      sensor_a_out <= goal_a_in;
      sensor_b_out <= goal_b_in;
    end else begin
      sensor_a_out <= sensor_a_out + 8'(goal_a_in > sensor_a_out) - 8'(goal_a_in < sensor_a_out);
      sensor_b_out <= sensor_b_out + 8'(goal_b_in > sensor_b_out) - 8'(goal_b_in < sensor_b_out);
    end
  end
endmodule // alz_light_model

//--- verification/alz_zone_ctrl_test.sv
// Testbench of the zone control block: registers, zone moves, ramp, interrupt, PWM.
// Assumes short sample and ramp bases: one averaging period is 128 cycles at code 0.
`timescale 1ns/100ps
module alz_zone_ctrl_test;
  localparam int LIMIT = 40000;
  logic sys_clk_in, reset_n_in, reg_wr_in, reg_rd_in, pwm_in, led_map_linear_out, led_drive_out;
  logic int_out, int_oe_n_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, led_level_out, goal_a, goal_b, sens_a, sens_b;
  logic [2:0] full_scale_led_current_out;
  logic [3:0] sensor_a_res_out, sensor_b_res_out;
  int fail_count, comparisons, cycles;

  alz_zone_ctrl #(.SAMPLE_BASE_CYCLES(4), .RAMP_BASE_CYCLES(3)) DUT (.sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .light_sensor_in_a(sens_a),
    .light_sensor_in_b(sens_b), .pwm_in(pwm_in), .led_level_out(led_level_out),
    .led_map_linear_out(led_map_linear_out), .full_scale_led_current_out(full_scale_led_current_out),
    .led_drive_out(led_drive_out), .sensor_a_res_out(sensor_a_res_out), .sensor_b_res_out(sensor_b_res_out),
    .int_out(int_out), .int_oe_n_out(int_oe_n_out));
  alz_light_model #(.SLEW(0)) u_light (.clk_in(sys_clk_in), .reset_n_in(reset_n_in), .goal_a_in(goal_a),
    .goal_b_in(goal_b), .sensor_a_out(sens_a), .sensor_b_out(sens_b));

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("Mismatches %0d of %0d comparisons", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    chk(reg_rdata_out, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // Bounded waits; a miss shows up as a mismatch, not a hang
  task automatic wait_int(input int n);
    for (int i = 0; i < n && int_oe_n_out !== 1'b0; i++) @(negedge sys_clk_in);
    chk({7'h00, int_oe_n_out}, 8'h00);
  endtask
  task automatic wait_level(input logic [7:0] exp, input int n);
    for (int i = 0; i < n && led_level_out !== exp; i++) @(negedge sys_clk_in);
    chk(led_level_out, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_registers;
    logic [7:0] rv [0:8];
    rv = '{8'h33, 8'h66, 8'h99, 8'hCC, 8'h19, 8'h33, 8'h4C, 8'h66, 8'h7F};
    for (int i = 0; i < 9; i++) rd(8'h05 + 8'(i), rv[i]);
    rd(8'h20, 8'h00);
    wr(8'h05, 8'h5A);
    rd(8'h05, 8'h5A);
    wr(8'h05, 8'h33);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h00);
    wr(8'h02, 8'h04);
    idle(2);
    chk({sensor_b_res_out, sensor_a_res_out}, 8'h04);
    wr(8'h00, 8'h15);
    idle(2);
    chk({4'h0, full_scale_led_current_out, led_map_linear_out}, 8'h0A);
  endtask
  task automatic t_zone_up;
    @(posedge sys_clk_in);
    goal_a <= 8'h70;
    wr(8'h00, 8'h01);
    wr(8'h01, 8'h10);
    idle(3);
    chk(led_level_out, 8'h00);
    wr(8'h01, 8'h38);
    idle(200);
    chk({7'h00, int_oe_n_out}, 8'h01);
    wait_int(600);
    rd(8'h04, 8'h92);
    rd(8'h04, 8'h12);
    wait_level(8'h4C, 400);
    chk({7'h00, led_drive_out}, 8'h01);
    wr(8'h00, 8'h21);
    pwm_in <= 1'b0;
    idle(3);
    chk({7'h00, led_drive_out}, 8'h00);
    @(posedge sys_clk_in);
    pwm_in <= 1'b1;
    idle(3);
    chk({7'h00, led_drive_out}, 8'h01);
    wr(8'h00, 8'h61);
    idle(3);
    chk({7'h00, led_drive_out}, 8'h00);
    wr(8'h00, 8'h01);
  endtask
  task automatic t_zone_down;
    logic [7:0] lvl;
    int i;
    wr(8'h03, 8'h2D);
    goal_a <= 8'h10;
    wait_int(400);
    rd(8'h04, 8'h80);
    lvl = led_level_out;
    for (i = 0; i < 200 && led_level_out === lvl; i++) @(negedge sys_clk_in);
    lvl = led_level_out;
    for (i = 0; i < 200 && led_level_out === lvl; i++) @(negedge sys_clk_in);
    chk(8'(i), 8'h60);
    wait_level(8'h19, 5000);
  endtask
  task automatic t_select_b;
    wr(8'h01, 8'h00);
    idle(3);
    chk(led_level_out, 8'h00);
    wr(8'h03, 8'h00);
    goal_a <= 8'h00;
    goal_b <= 8'h99;
    wr(8'h01, 8'h58);
    wait_int(600);
    rd(8'h04, 8'h92);
    wait_int(300);
    rd(8'h04, 8'h9B);
    idle(500);
    chk({7'h00, int_oe_n_out}, 8'h01);
    wait_level(8'h66, 400);
    rd(8'h0E, 8'h99);
    // Larger of both inputs; one lone upward move must not commit
    wr(8'h01, 8'h78);
    goal_a <= 8'hCC;
    idle(300);
    chk({7'h00, int_oe_n_out}, 8'h01);
    rd(8'h04, 8'h23);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      report_and_stop;
    end
  end
  initial begin
    {reset_n_in, reg_wr_in, reg_rd_in, pwm_in} = 4'h0;
    {reg_addr_in, reg_wdata_in, goal_a, goal_b} = 32'h0;
    {fail_count, comparisons, cycles} = '0;
    repeat (20) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    t_registers;
    t_zone_up;
    t_zone_down;
    t_select_b;
    report_and_stop;
  end
endmodule // alz_zone_ctrl_test
